// [dv/rtc_alarm_periodic_timer_tb_top.sv]
`timescale 1ns/1ps

module rtc_alarm_periodic_timer_tb_top;
   import rtcp_pkg::*;

   // =============================================================
   // Stimulus rows and bench state
   typedef struct packed {
      logic wr;
      logic [11:0] addr;
      logic [31:0] data;
      logic [31:0] exp;
   } rtcp_row_t;
   localparam rtcp_row_t ROWS [11] = '{
      '{1'b0, 12'h140, 32'h0, 32'h0}, '{1'b0, 12'h144, 32'h0, 32'h0},
      '{1'b0, 12'h150, 32'h0, 32'h0}, '{1'b0, 12'h154, 32'h0, 32'h0},
      '{1'b1, 12'h148, 32'hFFFFFFAB, 32'h000000AB}, '{1'b1, 12'h14C, 32'h12345678, 32'h12345678},
      '{1'b1, 12'h150, 32'hFFFFFF00, 32'h0}, '{1'b1, 12'h154, 32'hABCD1234, 32'h00001234},
      '{1'b1, 12'h140, 32'hFFFFFFFF, 32'h0}, '{1'b1, 12'h144, 32'hFFFFFFFF, 32'h0},
      '{1'b1, 12'h158, 32'hFFFFFFFF, 32'h0}};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel_b = 1'b0, hwrite_b = 1'b0, sck = 1'b0, tck = 1'b0;
   logic [1:0] htrans_b = 2'h0;
   logic [31:0] haddr_b = 32'h0, hwdata_b = 32'h0, rd;
   logic resp_b;
   rtcp_ahb_req_t ahb_req;
   rtcp_ahb_rsp_t ahb_rsp;
   logic buf_out, roll, alarm, per, tick;
   int err_total = 0, check_count = 0, n_roll = 0, n_alarm = 0, n_per = 0, n_tick = 0, cyc = 0;

   assign ahb_req = '{hsel: hsel_b, haddr: haddr_b, htrans: htrans_b, hwrite: hwrite_b,
                      hsize: 3'h2, hwdata: hwdata_b, hready: ahb_rsp.hreadyout};

   rtcp_timer uut (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
      .slow_crystal_clock(sck), .timer_tick_clock(tck), .slow_clock_buffer_out(buf_out),
      .rollover_event(roll), .alarm_match_event(alarm), .period_event(per),
      .ref_tick_8ms(tick));

   // Clock and event counters
   always #20 hclk = ~hclk;
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      n_roll <= n_roll + int'(roll !== 1'b0);
      n_alarm <= n_alarm + int'(alarm !== 1'b0);
      n_per <= n_per + int'(per !== 1'b0);
      n_tick <= n_tick + int'(tick !== 1'b0);
      if (cyc == 20000)
      begin
         err_total = err_total + 1;
         give_verdict();
      end
   end

   // =============================================================
   // Bus and pin tasks
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel_b <= 1'b1;
      haddr_b <= {20'h0, a};
      htrans_b <= 2'h2;
      hwrite_b <= wr;
      do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
      hsel_b <= 1'b0;
      htrans_b <= 2'h0;
      hwdata_b <= d;
      // Data phase ends at the edge that samples hready high
      do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
      rd = ahb_rsp.hrdata;
      resp_b = ahb_rsp.hresp;
   endtask : bus

   // Pulses on slow (sel 0) or timer (sel 1) clock, high for 4 cycles and low for 5 between pulses
   task automatic pulses(input logic sel, input int n);
      repeat (n)
      begin
         @(posedge hclk);
         if (sel) tck <= 1'b1; else sck <= 1'b1;
         repeat (4) @(posedge hclk);
         if (sel) tck <= 1'b0; else sck <= 1'b0;
         repeat (4) @(posedge hclk);
      end
      repeat (6) @(posedge hclk);
   endtask : pulses

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_events(input int got, input int exp);
      cmp_word(32'(got), 32'(exp));
   endtask : cmp_events

   task automatic rd_cmp(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      cmp_word(rd, exp);
      cmp_word({31'h0, resp_b}, 32'h0);
   endtask : rd_cmp

   // Live count read repeated until two reads agree
   task automatic rd_stable(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] first;
      bus(1'b0, a, 32'h0);
      do
      begin
         first = rd;
         bus(1'b0, a, 32'h0);
      end
      while (first !== rd);
      cmp_word(rd, exp);
   endtask : rd_stable

   // Clear time, set control, zero the event counts
   task automatic setup(input logic [7:0] c);
      bus(1'b1, 12'h150, 32'h08);
      bus(1'b1, 12'h150, {24'h0, c});
      // Zero off the edge so no counter update races the clear
      @(negedge hclk);
      n_roll = 0;
      n_alarm = 0;
      n_per = 0;
      n_tick = 0;
   endtask : setup

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, err_total);
   endtask : end_test

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // =============================================================
   // Main sequence
   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ROWS[i])
      begin
         if (ROWS[i].wr) bus(1'b1, ROWS[i].addr, ROWS[i].data);
         rd_cmp(ROWS[i].addr, ROWS[i].exp);
      end
      end_test("register table");
      bus(1'b1, 12'h148, 32'h05);
      bus(1'b1, 12'h14C, 32'h05050505);
      setup(8'h01);
      pulses(1'b0, 255);
      rd_cmp(12'h140, 32'hFF);
      rd_cmp(12'h144, 32'hFFFFFFFF);
      cmp_events(n_alarm, 1);
      cmp_events(n_roll, 0);
      pulses(1'b0, 1);
      rd_cmp(12'h144, 32'h0);
      cmp_events(n_roll, 1);
      end_test("parallel rollover and alarm");
      setup(8'h00);
      pulses(1'b0, 256);
      rd_cmp(12'h144, 32'h100);
      rd_stable(12'h144, 32'h100);
      cmp_events(n_tick, 1);
      @(posedge hclk) sck <= 1'b1;
      repeat (5) @(posedge hclk);
      cmp_word({31'h0, buf_out}, 32'h1);
      sck <= 1'b0;
      repeat (5) @(posedge hclk);
      cmp_word({31'h0, buf_out}, 32'h0);
      rd_cmp(12'h144, 32'h101);
      end_test("cascade count");
      setup(8'h41);
      pulses(1'b0, 2);
      rd_cmp(12'h144, 32'h2);
      rd_cmp(12'h140, 32'h0);
      bus(1'b1, 12'h150, 32'h80);
      pulses(1'b0, 3);
      rd_cmp(12'h144, 32'h2);
      end_test("freeze");
      setup(8'h08);
      pulses(1'b0, 3);
      rd_cmp(12'h144, 32'h0);
      bus(1'b1, 12'h150, 32'h00);
      pulses(1'b0, 1);
      rd_cmp(12'h144, 32'h1);
      setup(8'h02);
      pulses(1'b1, 5);
      pulses(1'b0, 2);
      rd_cmp(12'h144, 32'h5);
      setup(8'h04);
      pulses(1'b0, 6);
      cmp_events(n_tick, 3);
      end_test("clear, test clock, fast tick");
      bus(1'b1, 12'h154, 32'h3);
      setup(8'h10);
      pulses(1'b1, 2);
      rd_cmp(12'h154, 32'h00010003);
      rd_stable(12'h154, 32'h00010003);
      pulses(1'b1, 6);
      cmp_events(n_per, 2);
      setup(8'h30);
      pulses(1'b1, 8);
      cmp_events(n_per, 0);
      rd_cmp(12'h154, 32'h00030003);
      bus(1'b1, 12'h154, 32'h0);
      setup(8'h10);
      pulses(1'b1, 2);
      cmp_events(n_per, 2);
      setup(8'h00);
      rd_cmp(12'h154, 32'h0);
      pulses(1'b1, 8);
      cmp_events(n_per, 0);
      end_test("periodic timer");
      // Reset in mid-run returns the registers to zero
      bus(1'b1, 12'h154, 32'h3);
      bus(1'b1, 12'h150, 32'h10);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd_cmp(12'h148, 32'h0);
      rd_cmp(12'h14C, 32'h0);
      rd_cmp(12'h150, 32'h0);
      rd_cmp(12'h154, 32'h0);
      end_test("mid-run reset");
      give_verdict();
   end

endmodule : rtc_alarm_periodic_timer_tb_top

// [src/rtcp_pkg.sv]
// =============================================================
// Timer unit constants and carriers
package rtcp_pkg;

   // Register byte offsets
   localparam logic [11:0] RTCP_OFF_TIME_HI = 12'h140;
   localparam logic [11:0] RTCP_OFF_TIME_LO = 12'h144;
   localparam logic [11:0] RTCP_OFF_ALARM_HI = 12'h148;
   localparam logic [11:0] RTCP_OFF_ALARM_LO = 12'h14C;
   localparam logic [11:0] RTCP_OFF_CTRL = 12'h150;
   localparam logic [11:0] RTCP_OFF_PERIOD = 12'h154;

   // Widths
   localparam int RTCP_STAGES = 5;
   localparam int RTCP_STAGE_W = 8;
   localparam int RTCP_TIME_W = 40;
   localparam int RTCP_PER_W = 16;

   // Control bit positions
   localparam int RTCP_CB_FREEZE_LOW = 7;
   localparam int RTCP_CB_FREEZE_HIGH = 6;
   localparam int RTCP_CB_FREEZE_PER = 5;
   localparam int RTCP_CB_PER_EN = 4;
   localparam int RTCP_CB_CLEAR = 3;
   localparam int RTCP_CB_FAST_TICK = 2;
   localparam int RTCP_CB_TEST_CLK = 1;
   localparam int RTCP_CB_PARALLEL = 0;
   localparam logic [7:0] RTCP_CTRL_RST = 8'h00;

   // Periodic register field positions
   localparam int RTCP_PER_COUNT_LSB = 16;
   localparam int RTCP_PER_RELOAD_LSB = 0;

   // Test reference tick: 61 us in slow clock edges, rounded up
   localparam int RTCP_SLOW_HZ = 32768;
   localparam int RTCP_TEST_TICK_US = 61;
   localparam int RTCP_TEST_TICK_EDGES =
      (RTCP_TEST_TICK_US * RTCP_SLOW_HZ + 999999) / 1000000;
   localparam logic [3:0] RTCP_TEST_TICK_LAST = 4'(RTCP_TEST_TICK_EDGES - 1);

   // AHB-Lite request from the master
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } rtcp_ahb_req_t;

   // AHB-Lite response to the master
   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } rtcp_ahb_rsp_t;

   // Whole state of the timer unit
   typedef struct packed {
      logic [1:0] slow_sync;
      logic slow_prev;
      logic [1:0] tmr_sync;
      logic tmr_prev;
      logic clk_buf;
      logic [39:0] rtc;
      logic [39:0] alarm;
      logic [7:0] ctrl;
      logic [15:0] reload;
      logic [15:0] count;
      logic run;
      logic match;
      logic roll_ev;
      logic alarm_ev;
      logic per_ev;
      logic tick;
      logic [3:0] tcnt;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] hrdata;
      logic hready;
   } rtcp_state_t;

   localparam rtcp_state_t RTCP_STATE_RST = '{hready: 1'b1, ctrl: RTCP_CTRL_RST,
                                              default: '0};

endpackage : rtcp_pkg

// [src/rtcp_timer.sv]
// Behaviour
// - 40-bit time counter steps once per slow crystal clock cycle.
// - Five cascaded 8-bit stages; later stage steps while all earlier stages all ones.
// - Full 40-bit wrap from all ones raises the rollover event.
// - Time counter equal to the 40-bit alarm value raises the alarm event.
// - Time count read as high word bits 7-0 and low word bits 31-0.
// - Periodic timer is a 16-bit down-counter on the timer clock, loaded from reload.
// - Enabled counter loads reload, counts down, at zero raises event and reloads.
// - Period event only while enabled; disabled zero gives no event.
// - Period events are reload plus one timer clock periods apart.
// - Control bit 7 freezes the low time stage and stops the reference tick.
// - Control bit 6 freezes the upper 32 time bits only.
// - Control bit 5 holds the periodic counter at its present value.
// - Control bit 3 forces the time counter to zero until cleared.
// - Control bit 2 makes the reference tick run at a 61 us period.
// - Control bit 1 clocks the time counter from the timer clock.
// - Control bit 0 makes all five stages step together.
// - A buffered copy of the slow crystal clock drives a dedicated output.
`timescale 1ns/1ps

module rtcp_timer (
   // Bus clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave port
   input wire rtcp_pkg::rtcp_ahb_req_t ahb_req,
   output rtcp_pkg::rtcp_ahb_rsp_t ahb_rsp,
   // Timer clock inputs
   input wire logic slow_crystal_clock,
   input wire logic timer_tick_clock,
   // Clock copy and events
   output logic slow_clock_buffer_out,
   output logic rollover_event,
   output logic alarm_match_event,
   output logic period_event,
   output logic ref_tick_8ms
);
   import rtcp_pkg::*;

   // =============================================================
   // State and helper signals
   rtcp_state_t s_r;
   rtcp_state_t s_nxt;
   logic slow_edge;
   logic tmr_edge;
   logic src_edge;
   logic rtc_hold;
   logic [RTCP_STAGES-1:0] stage_ones;
   logic [RTCP_STAGES-1:0] below_ones;
   logic [RTCP_STAGES-1:0] stage_inc;
   logic [RTCP_TIME_W-1:0] rtc_adv;
   logic addr_ok;

   // Read view of the register map
   function automatic logic [31:0] rtcp_read(input rtcp_state_t s, input logic [11:0] a);
      logic [31:0] d;
      d = 32'h0;
      case (a)
         RTCP_OFF_TIME_HI: d = {24'h0, s.rtc[39:32]};
         RTCP_OFF_TIME_LO: d = s.rtc[31:0];
         RTCP_OFF_ALARM_HI: d = {24'h0, s.alarm[39:32]};
         RTCP_OFF_ALARM_LO: d = s.alarm[31:0];
         RTCP_OFF_CTRL: d = {24'h0, s.ctrl};
         RTCP_OFF_PERIOD: d = {s.count, s.reload};
         default: d = 32'h0;
      endcase
      return d;
   endfunction : rtcp_read

   // Edges of the synchronised timer clocks
   assign slow_edge = s_r.slow_sync[1] & ~s_r.slow_prev;
   assign tmr_edge = s_r.tmr_sync[1] & ~s_r.tmr_prev;
   // Test mode swaps the time counter source
   assign src_edge = s_r.ctrl[RTCP_CB_TEST_CLK] ? tmr_edge : slow_edge;
   assign rtc_hold = s_r.ctrl[RTCP_CB_CLEAR];

   // =============================================================
   // Cascaded 8-bit stages of the time counter
   genvar g;
   generate
      for (g = 0; g < RTCP_STAGES; g++)
      begin : g_stage
         assign stage_ones[g] = &s_r.rtc[g*RTCP_STAGE_W +: RTCP_STAGE_W];
         if (g == 0)
         begin : g_first
            assign below_ones[g] = 1'b1;
            // First stage counts each source edge while neither clear nor freeze-low is set
            assign stage_inc[g] = src_edge & ~rtc_hold &
                                  ~s_r.ctrl[RTCP_CB_FREEZE_LOW];
         end
         else
         begin : g_upper
            assign below_ones[g] = below_ones[g-1] & stage_ones[g-1];
            // Carry from all-ones lower stages, or all together in parallel mode
            assign stage_inc[g] = src_edge & ~rtc_hold & ~s_r.ctrl[RTCP_CB_FREEZE_HIGH] &
                                  (below_ones[g] | s_r.ctrl[RTCP_CB_PARALLEL]);
         end
         assign rtc_adv[g*RTCP_STAGE_W +: RTCP_STAGE_W] = stage_inc[g] ?
            s_r.rtc[g*RTCP_STAGE_W +: RTCP_STAGE_W] + 8'h01 :
            s_r.rtc[g*RTCP_STAGE_W +: RTCP_STAGE_W];
      end
   endgenerate

   // Address phase of a transfer aimed at this slave
   assign addr_ok = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

   // =============================================================
   // Next-state logic
   always_comb
   begin
      s_nxt = s_r;
      // Two-stage synchronisers and clock copy
      s_nxt.slow_sync = {s_r.slow_sync[0], slow_crystal_clock};
      s_nxt.tmr_sync = {s_r.tmr_sync[0], timer_tick_clock};
      s_nxt.slow_prev = s_r.slow_sync[1];
      s_nxt.tmr_prev = s_r.tmr_sync[1];
      s_nxt.clk_buf = s_r.slow_sync[1];
      s_nxt.roll_ev = 1'b0;
      s_nxt.alarm_ev = 1'b0;
      s_nxt.per_ev = 1'b0;
      s_nxt.tick = 1'b0;

      // Time counter, clear wins over counting
      if (rtc_hold)
      begin
         s_nxt.rtc = 40'h0;
      end
      else
      begin
         s_nxt.rtc = rtc_adv;
      end
      // Wrap from all ones to zero
      s_nxt.roll_ev = ~rtc_hold & (&s_r.rtc) & (rtc_adv == 40'h0);

      // Reference tick from low stage steps
      if (stage_inc[0])
      begin
         if (s_r.ctrl[RTCP_CB_FAST_TICK])
         begin
            s_nxt.tcnt = (s_r.tcnt == RTCP_TEST_TICK_LAST) ? 4'h0 : s_r.tcnt + 4'h1;
            s_nxt.tick = (s_r.tcnt == RTCP_TEST_TICK_LAST);
         end
         else
         begin
            s_nxt.tcnt = 4'h0;
            s_nxt.tick = stage_ones[0];
         end
      end

      // Periodic down-counter
      if (!s_r.ctrl[RTCP_CB_PER_EN])
      begin
         s_nxt.run = 1'b0;
      end
      else if (!s_r.run)
      begin
         s_nxt.run = 1'b1;
         s_nxt.count = s_r.reload;
      end
      else if (tmr_edge && !s_r.ctrl[RTCP_CB_FREEZE_PER])
      begin
         if (s_r.count == 16'h0)
         begin
            s_nxt.per_ev = 1'b1;
            s_nxt.count = s_r.reload;
         end
         else
         begin
            s_nxt.count = s_r.count - 16'h1;
         end
      end

      // Data phase of a write
      if (s_r.wr_pend)
      begin
         case (s_r.wr_addr)
            RTCP_OFF_ALARM_HI: s_nxt.alarm[39:32] = ahb_req.hwdata[7:0];
            RTCP_OFF_ALARM_LO: s_nxt.alarm[31:0] = ahb_req.hwdata;
            RTCP_OFF_CTRL: s_nxt.ctrl = ahb_req.hwdata[7:0];
            RTCP_OFF_PERIOD: s_nxt.reload = ahb_req.hwdata[RTCP_PER_RELOAD_LSB +: RTCP_PER_W];
            default: s_nxt.wr_pend = 1'b0;
         endcase
      end

      // Equality with the alarm, event on becoming equal
      s_nxt.match = (s_nxt.rtc == s_nxt.alarm);
      s_nxt.alarm_ev = s_nxt.match & ~s_r.match;

      // Address phase capture and read data
      s_nxt.wr_pend = addr_ok & ahb_req.hwrite;
      s_nxt.wr_addr = ahb_req.haddr[11:0];
      s_nxt.hready = 1'b1;
      if (addr_ok && !ahb_req.hwrite)
      begin
         s_nxt.hrdata = rtcp_read(s_nxt, ahb_req.haddr[11:0]);
      end
      else
      begin
         s_nxt.hrdata = 32'h0;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r <= RTCP_STATE_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from state, hresp tied to zero
   assign ahb_rsp.hrdata = s_r.hrdata;
   assign ahb_rsp.hreadyout = s_r.hready;
   assign ahb_rsp.hresp = 1'b0;
   assign slow_clock_buffer_out = s_r.clk_buf;
   assign rollover_event = s_r.roll_ev;
   assign alarm_match_event = s_r.alarm_ev;
   assign period_event = s_r.per_ev;
   assign ref_tick_8ms = s_r.tick;

   // =============================================================
   // Assertions
   property p_time_step;
      @(posedge hclk) disable iff (!hresetn)
      slow_edge && s_r.ctrl == 8'h00 |=> s_r.rtc == $past(s_r.rtc) + 40'h1;
   endproperty
   a_time_step: assert property (p_time_step)
      else $error("time counter did not step on slow edge");

   property p_upper_hold;
      @(posedge hclk) disable iff (!hresetn)
      src_edge && !stage_ones[0] && !s_r.ctrl[RTCP_CB_PARALLEL] && !rtc_hold
      |=> s_r.rtc[39:8] == $past(s_r.rtc[39:8]);
   endproperty
   a_upper_hold: assert property (p_upper_hold)
      else $error("upper stages moved without carry");

   property p_rollover;
      @(posedge hclk) disable iff (!hresetn)
      rollover_event |-> s_r.rtc == 40'h0 && $past(&s_r.rtc);
   endproperty
   a_rollover: assert property (p_rollover)
      else $error("rollover event without wrap");

   property p_alarm;
      @(posedge hclk) disable iff (!hresetn)
      alarm_match_event |-> s_r.rtc == s_r.alarm;
   endproperty
   a_alarm: assert property (p_alarm)
      else $error("alarm event without match");

   property p_read_low;
      @(posedge hclk) disable iff (!hresetn)
      addr_ok && !ahb_req.hwrite && ahb_req.haddr[11:0] == RTCP_OFF_TIME_LO
      |=> ahb_rsp.hrdata == s_r.rtc[31:0];
   endproperty
   a_read_low: assert property (p_read_low)
      else $error("low time word read wrong");

   property p_period_reload;
      @(posedge hclk) disable iff (!hresetn)
      period_event |-> $past(s_r.count) == 16'h0 && s_r.count == $past(s_r.reload);
   endproperty
   a_period_reload: assert property (p_period_reload)
      else $error("period event without zero and reload");

   property p_period_enabled;
      @(posedge hclk) disable iff (!hresetn)
      period_event |-> $past(s_r.ctrl[RTCP_CB_PER_EN]) && $past(s_r.run);
   endproperty
   a_period_enabled: assert property (p_period_enabled)
      else $error("period event while disabled");

   property p_freeze_low;
      @(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[RTCP_CB_FREEZE_LOW] && !rtc_hold
      |=> s_r.rtc[7:0] == $past(s_r.rtc[7:0]) && !ref_tick_8ms;
   endproperty
   a_freeze_low: assert property (p_freeze_low)
      else $error("low stage or tick moved while frozen");

   property p_freeze_high;
      @(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[RTCP_CB_FREEZE_HIGH] && !rtc_hold |=> s_r.rtc[39:8] == $past(s_r.rtc[39:8]);
   endproperty
   a_freeze_high: assert property (p_freeze_high)
      else $error("upper stages moved while frozen");

   property p_freeze_per;
      @(posedge hclk) disable iff (!hresetn)
      s_r.run && s_r.ctrl[RTCP_CB_FREEZE_PER] |=> s_r.count == $past(s_r.count) && !period_event;
   endproperty
   a_freeze_per: assert property (p_freeze_per)
      else $error("period counter moved while frozen");

   property p_clear;
      @(posedge hclk) disable iff (!hresetn)
      rtc_hold |=> s_r.rtc == 40'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("time counter not held at zero");

   property p_buffer;
      @(posedge hclk) disable iff (!hresetn)
      $rose(s_r.slow_sync[1]) |=> slow_clock_buffer_out;
   endproperty
   a_buffer: assert property (p_buffer)
      else $error("clock copy did not follow input");

   property p_enable_load;
      @(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[RTCP_CB_PER_EN] && !s_r.run |=> s_r.run && s_r.count == $past(s_r.reload);
   endproperty
   a_enable_load: assert property (p_enable_load)
      else $error("enable did not load the reload value");

   property p_period_step;
      @(posedge hclk) disable iff (!hresetn)
      s_r.run && s_r.ctrl[RTCP_CB_PER_EN] && !s_r.ctrl[RTCP_CB_FREEZE_PER] && tmr_edge &&
      s_r.count != 16'h0 |=> s_r.count == $past(s_r.count) - 16'h1 && !period_event;
   endproperty
   a_period_step: assert property (p_period_step)
      else $error("period counter did not step down");

   property p_period_idle;
      @(posedge hclk) disable iff (!hresetn)
      !s_r.ctrl[RTCP_CB_PER_EN] |=> !period_event;
   endproperty
   a_period_idle: assert property (p_period_idle)
      else $error("period event while enable clear");

   property p_tick_normal;
      @(posedge hclk) disable iff (!hresetn)
      ref_tick_8ms && !$past(s_r.ctrl[RTCP_CB_FAST_TICK]) |-> s_r.rtc[7:0] == 8'h00;
   endproperty
   a_tick_normal: assert property (p_tick_normal)
      else $error("reference tick without low stage wrap");

   property p_fast_tick;
      @(posedge hclk) disable iff (!hresetn)
      ref_tick_8ms && $past(s_r.ctrl[RTCP_CB_FAST_TICK]) |-> $past(s_r.tcnt) == RTCP_TEST_TICK_LAST;
   endproperty
   a_fast_tick: assert property (p_fast_tick)
      else $error("fast tick at wrong step");

   property p_test_source;
      @(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[RTCP_CB_TEST_CLK] && !tmr_edge && !rtc_hold |=> s_r.rtc == $past(s_r.rtc);
   endproperty
   a_test_source: assert property (p_test_source)
      else $error("time counter moved without timer edge in test mode");

   property p_parallel;
      @(posedge hclk) disable iff (!hresetn)
      src_edge && s_r.ctrl[RTCP_CB_PARALLEL] && !rtc_hold && !s_r.ctrl[RTCP_CB_FREEZE_LOW] &&
      !s_r.ctrl[RTCP_CB_FREEZE_HIGH] |=> s_r.rtc[39:32] == $past(s_r.rtc[39:32]) + 8'h01 &&
      s_r.rtc[7:0] == $past(s_r.rtc[7:0]) + 8'h01;
   endproperty
   a_parallel: assert property (p_parallel)
      else $error("stages did not step together");

   property p_sync;
      @(posedge hclk) disable iff (!hresetn)
      $rose(s_r.slow_sync[1]) |-> $past(slow_crystal_clock, 2);
   endproperty
   a_sync: assert property (p_sync)
      else $error("slow clock synchroniser out of step");

   // Main scenarios
   c_rollover: cover property (@(posedge hclk) disable iff (!hresetn) rollover_event);
   c_alarm: cover property (@(posedge hclk) disable iff (!hresetn) alarm_match_event);
   c_period: cover property (@(posedge hclk) disable iff (!hresetn) period_event);
   c_tick: cover property (@(posedge hclk) disable iff (!hresetn) ref_tick_8ms);
   c_clear: cover property (@(posedge hclk) disable iff (!hresetn) rtc_hold && src_edge);

endmodule : rtcp_timer
